/* File: rtl/spi_clock_stop_defs.svh */
`ifndef SPI_CLOCK_STOP_DEFS_SVH
`define SPI_CLOCK_STOP_DEFS_SVH

// Clock-stop setting handled by this block and the required polarities.
`define CLOCK_STOP_MODE_DELAYED 2'h3
`define TX_CLOCK_POLARITY_REQ   1'h1
`define FSYNC_POLARITY_REQ      1'h1
// Sample-rate input period in CPU clocks when the internal source is chosen.
`define SRG_INTERNAL_DIV        8'h02
// Settings required in slave modes.
`define SRG_SLAVE_SOURCE        1'h1
`define SRG_SLAVE_DIVIDER       8'h01
`define FRAME_WORD_BITS         8
`define FIFO_DEPTH_DEF          8

`endif

/* File: rtl/spi_clock_stop_pkg.sv */
package spi_clock_stop_pkg;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SELECT = 2'b01,
      ST_SHIFT  = 2'b10,
      ST_FINISH = 2'b11
   } xfer_state_e;
endpackage

/* File: rtl/spi_clock_stop.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_clock_stop_defs.svh"

module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   // Ready looks only at the count, so a full FIFO refuses a word even as one leaves.
   assign in_ready_o  = (count_r < (AW+1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = ce_i && in_valid_i && in_ready_o;
   assign pop         = ce_i && out_valid_o && out_ready_i;

   // Storage has no reset; the count alone says which entries hold words.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// How it works
// - Sample-rate input is two CPU clocks when source select is 1, else external clock.
// - Bit-clock period equals divider plus one sample-rate input periods; a divider of zero gives two.
// - High phase is divider/2+1 periods when even, (divider+1)/2 when odd or zero.
// - Low phase is divider/2 periods when even, (divider+1)/2 when odd or zero.
// - Slave mode expects source select and divider both set to one.
// - Both frame-sync polarities are one; master drives inverted, active-low select.
// - Slave inverts the active-low select arriving on either frame-sync pin.
// - Master drives transmit clock and frame sync; receive ones are inputs.
// - Slave takes all clock and frame-sync pins as inputs.
// - Master drives select low before a rising edge; transfer starts on rising edge.
// - Outgoing data bits launch on the rising bit-clock edge.
// - Incoming data bits are captured on the rising bit-clock edge.
// - After the last bit the data output is released to high impedance.
// - Master drives the first bit after select, delayed by one low phase.
module spi_clock_stop
   import spi_clock_stop_pkg::*;
#(
   parameter int WORD_BITS  = `FRAME_WORD_BITS,
   parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
   // Clock, reset and enable
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   // Configuration
   input  wire logic                 master_i,
   input  wire logic [1:0]           clock_stop_mode_i,
   input  wire logic                 tx_clock_polarity_i,
   input  wire logic                 tx_fsync_polarity_i,
   input  wire logic                 rx_fsync_polarity_i,
   input  wire logic                 srg_clock_source_select_i,
   input  wire logic [7:0]           srg_clock_divider_i,
   input  wire logic                 srg_ext_clock_i,
   // Transmit word stream
   input  wire logic                 tx_valid_i,
   output logic                      tx_ready_o,
   input  wire logic [WORD_BITS-1:0] tx_data_i,
   // Receive word stream
   output logic                      rx_valid_o,
   output logic [WORD_BITS-1:0]      rx_data_o,
   // Pins; bit clock and transmit frame sync each have input, output and active-low output enable
   input  wire logic                 bit_clock_tx_i,
   output logic                      bit_clock_tx_o,
   output logic                      bit_clock_tx_oe_n_o,
   input  wire logic                 tx_frame_sync_i,
   output logic                      tx_frame_sync_o,
   output logic                      tx_frame_sync_oe_n_o,
   input  wire logic                 rx_frame_sync_i,
   output logic                      serial_data_out_o,
   output logic                      serial_data_out_oe_n_o,
   input  wire logic                 serial_data_in_i,
   // Status
   output logic                      srg_output_clock_o,
   output logic                      busy_o,
   output logic                      config_error_o,
   output logic                      tx_clock_dir_o,
   output logic                      rx_clock_dir_o,
   output logic                      tx_fsync_dir_o,
   output logic                      rx_fsync_dir_o
);
   localparam int BW = $clog2(WORD_BITS + 1);

   xfer_state_e          state_r;
   logic [3:0]           sync0_r;
   logic [3:0]           sync1_r;
   logic                 sclk_prev_r;
   logic                 ext_prev_r;
   logic [1:0]           ext_sync_r;
   logic                 half_r;
   logic                 srg_tick;
   logic [7:0]           phase_cnt_r;
   logic                 clk_level_r;
   logic                 clk_rise;
   logic                 clk_fall;
   logic [7:0]           high_len;
   logic [7:0]           low_len;
   logic                 div_odd_or_zero;
   logic [WORD_BITS-1:0] shift_r;
   logic [WORD_BITS-1:0] rx_shift_r;
   logic [BW-1:0]        bit_cnt_r;
   logic                 select_r;
   logic                 drive_r;
   logic                 dout_r;
   logic                 slave_sel;
   logic                 sclk_in;
   logic                 rise_edge;
   logic                 mode_ok;
   logic                 slave_cfg_bad;
   logic                 f_valid;
   logic                 f_ready;
   logic [WORD_BITS-1:0] f_data;

   word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_data_i),
      .out_valid_o (f_valid),
      .out_ready_i (f_ready),
      .out_data_o  (f_data)
   );

   // Pin inputs pass two flops; bit 0 clock, bits 1 and 2 the selects, bit 3 data.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync0_r <= 4'hF;
         sync1_r <= 4'hF;
         sclk_prev_r <= 1'h1;
      end else if (ce_i) begin
         sync0_r <= {serial_data_in_i, rx_frame_sync_i, tx_frame_sync_i, bit_clock_tx_i};
         sync1_r <= sync0_r;
         sclk_prev_r <= sync1_r[0];
      end
   end

   // The external rate clock gets its own two-flop synchroniser; only its rise matters.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_sync_r <= 2'h0;
         ext_prev_r <= 1'h0;
      end else if (ce_i) begin
         ext_sync_r <= {ext_sync_r[0], srg_ext_clock_i};
         ext_prev_r <= ext_sync_r[1];
      end
   end

   assign sclk_in   = sync1_r[0];
   // Active-low select from either frame-sync pin turns into an active-high enable.
   assign slave_sel = ~(sync1_r[1] & sync1_r[2]);

   assign mode_ok = (clock_stop_mode_i == `CLOCK_STOP_MODE_DELAYED)
                  && (tx_clock_polarity_i == `TX_CLOCK_POLARITY_REQ)
                  && (tx_fsync_polarity_i == `FSYNC_POLARITY_REQ)
                  && (rx_fsync_polarity_i == `FSYNC_POLARITY_REQ);
   // Wrong slave settings are only flagged; the port still runs so the fault shows.
   assign slave_cfg_bad  = !master_i
                         && ((srg_clock_source_select_i != `SRG_SLAVE_SOURCE)
                         || (srg_clock_divider_i != `SRG_SLAVE_DIVIDER));
   assign config_error_o = !mode_ok || slave_cfg_bad;

   // Internal source: a tick every second cycle gives the two-clock input period.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_r <= 1'h0;
      end else if (ce_i) begin
         half_r <= half_r + 1'b1;
      end
   end

   assign srg_tick = srg_clock_source_select_i ? half_r
                   : (ext_sync_r[1] & ~ext_prev_r);

   // Odd dividers split the period evenly; even ones give the spare tick to high.
   always_comb begin
      div_odd_or_zero = srg_clock_divider_i[0] || (srg_clock_divider_i == 8'h00);
      if (div_odd_or_zero) begin
         high_len = 8'((9'(srg_clock_divider_i) + 9'h001) >> 1);
         low_len  = 8'((9'(srg_clock_divider_i) + 9'h001) >> 1);
      end else begin
         high_len = 8'((srg_clock_divider_i >> 1) + 8'h01);
         low_len  = 8'(srg_clock_divider_i >> 1);
      end
   end

   // Phase counter reloads at each boundary; high plus low sums to divider plus one, or to two ticks for divider zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_cnt_r <= 8'h00;
         clk_level_r <= 1'h1;
      end else if (ce_i && srg_tick) begin
         if (phase_cnt_r + 8'h01 >= (clk_level_r ? high_len : low_len)) begin
            phase_cnt_r <= 8'h00;
            clk_level_r <= ~clk_level_r;
         end else begin
            phase_cnt_r <= phase_cnt_r + 8'h01;
         end
      end
   end

   assign clk_rise = ce_i && srg_tick && !clk_level_r
                   && (phase_cnt_r + 8'h01 >= low_len);
   assign clk_fall = ce_i && srg_tick && clk_level_r
                   && (phase_cnt_r + 8'h01 >= high_len);
   assign srg_output_clock_o = clk_level_r;

   // A slave sees the pin clock two cycles late, through the two-flop synchroniser; the edge flop only holds the old level.
   assign rise_edge = master_i ? clk_rise : (ce_i && sclk_in && !sclk_prev_r);

   assign f_ready = ce_i && (state_r == ST_IDLE) && f_valid
                  && mode_ok && (master_i ? clk_fall : slave_sel);

   // Transfer sequencer for both roles.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r    <= ST_IDLE;
         shift_r    <= '0;
         bit_cnt_r  <= '0;
         select_r   <= 1'h0;
         drive_r    <= 1'h0;
         dout_r     <= 1'h0;
      end else if (ce_i) begin
         unique case (state_r)
            // A master takes a word from the FIFO only at a clock fall, so select never cuts a phase; a slave takes it once selected.
            ST_IDLE: begin
               if (f_ready) begin
                  shift_r   <= f_data;
                  bit_cnt_r <= '0;
                  select_r  <= master_i;
                  state_r   <= ST_SELECT;
               end
            end
            ST_SELECT: begin
               // First bit appears one low phase after select, on a rising edge.
               if (rise_edge) begin
                  dout_r  <= shift_r[WORD_BITS-1];
                  drive_r <= 1'h1;
                  state_r <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (rise_edge) begin
                  shift_r    <= {shift_r[WORD_BITS-2:0], 1'b0};
                  bit_cnt_r  <= bit_cnt_r + 1'b1;
                  if (bit_cnt_r == BW'(WORD_BITS - 1)) begin
                     drive_r    <= 1'h0;
                     state_r    <= ST_FINISH;
                  end else begin
                     dout_r <= shift_r[WORD_BITS-2];
                  end
               end
            end
            ST_FINISH: begin
               // Master holds select through the last high phase; slave waits for deselect.
               if (master_i ? clk_fall : !slave_sel) begin
                  select_r <= 1'h0;
                  state_r  <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // The word is handed over on the rise that shifts in its last bit.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_shift_r <= '0;
         rx_valid_o <= 1'h0;
         rx_data_o  <= '0;
      end else if (ce_i) begin
         rx_valid_o <= 1'h0;
         if ((state_r == ST_SHIFT) && rise_edge) begin
            rx_shift_r <= {rx_shift_r[WORD_BITS-2:0], sync1_r[3]};
            if (bit_cnt_r == BW'(WORD_BITS - 1)) begin
               rx_data_o  <= {rx_shift_r[WORD_BITS-2:0], sync1_r[3]};
               rx_valid_o <= 1'h1;
            end
         end
      end
   end

   // Busy covers the wait for deselect, so a slave word is not done too early.
   assign busy_o = (state_r != ST_IDLE);

   // Receive clock and select are always inputs; only the transmit pair follows the role.
   assign tx_clock_dir_o = master_i;
   assign tx_fsync_dir_o = master_i;
   assign rx_clock_dir_o = 1'b0;
   assign rx_fsync_dir_o = 1'b0;

   // The bit clock idles high in clock-stop operation; it runs only while selected.
   assign bit_clock_tx_o       = select_r ? clk_level_r : 1'b1;
   assign bit_clock_tx_oe_n_o  = ~master_i;
   assign tx_frame_sync_o      = ~select_r;
   assign tx_frame_sync_oe_n_o = ~master_i;
   assign serial_data_out_o    = dout_r;
   assign serial_data_out_oe_n_o = ~drive_r;
endmodule

`default_nettype wire

/* File: verification/spi_clock_stop_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_clock_stop_checker #(
   parameter int WORD_BITS = 8
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       master_i,
   input wire logic [1:0] clock_stop_mode_i,
   input wire logic       srg_clock_source_select_i,
   input wire logic [7:0] srg_clock_divider_i,
   input wire logic       bit_clock_tx_o,
   input wire logic       bit_clock_tx_oe_n_o,
   input wire logic       tx_frame_sync_o,
   input wire logic       tx_frame_sync_oe_n_o,
   input wire logic       serial_data_out_o,
   input wire logic       serial_data_out_oe_n_o,
   input wire logic       rx_valid_o,
   input wire logic       busy_o,
   input wire logic       config_error_o,
   input wire logic       tx_clock_dir_o,
   input wire logic       rx_clock_dir_o,
   input wire logic       tx_fsync_dir_o,
   input wire logic       rx_fsync_dir_o
);
   logic [9:0] run_r;
   logic       seen_r;
   logic [3:0] rise_r;
   int         hi_w;
   int         lo_w;
   // Widths are in clock cycles: one internal rate tick is two cycles.
   assign hi_w = 2 * (srg_clock_divider_i[0] ? (srg_clock_divider_i + 1) / 2
                                             : srg_clock_divider_i / 2 + 1);
   assign lo_w = 2 * (srg_clock_divider_i[0] ? (srg_clock_divider_i + 1) / 2
                                             : srg_clock_divider_i / 2);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= 10'h1;
         seen_r <= 1'b0;
         rise_r <= 4'h0;
      end else begin
         run_r <= $changed(bit_clock_tx_o) ? 10'h1 : run_r + 10'h1;
         seen_r <= !tx_frame_sync_o && (seen_r || $changed(bit_clock_tx_o));
         rise_r <= serial_data_out_oe_n_o ? 4'h0 : rise_r + 4'($rose(bit_clock_tx_o));
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // The first edge inside a frame only opens the measurement.
   sequence frame_edge_s;
      master_i && srg_clock_source_select_i && srg_clock_divider_i != 8'h0 && seen_r
         && !tx_frame_sync_o && $changed(bit_clock_tx_o);
   endsequence
   high_width_a: assert property (frame_edge_s ##0 !bit_clock_tx_o |-> run_r == hi_w)
      else $error("bit clock high phase has the wrong length");
   low_width_a: assert property (frame_edge_s ##0 bit_clock_tx_o |-> run_r == lo_w)
      else $error("bit clock low phase has the wrong length");
   tx_dirs_a: assert property (tx_clock_dir_o == master_i && tx_fsync_dir_o == master_i)
      else $error("transmit directions do not follow master mode");
   rx_dirs_a: assert property (!rx_clock_dir_o && !rx_fsync_dir_o)
      else $error("receive directions are not inputs");
   pin_enable_a: assert property ($past(master_i) == master_i |->
      bit_clock_tx_oe_n_o == !master_i && tx_frame_sync_oe_n_o == !master_i)
      else $error("clock or select pin drive does not follow master mode");
   launch_rise_a: assert property (master_i && !serial_data_out_oe_n_o
      && $stable(serial_data_out_oe_n_o) && $changed(serial_data_out_o) |-> $rose(bit_clock_tx_o))
      else $error("data changed away from a rising bit clock edge");
   word_bound_a: assert property (rise_r <= WORD_BITS)
      else $error("data output driven beyond one word");
   select_lead_a: assert property (master_i && $fell(serial_data_out_oe_n_o) |->
      !tx_frame_sync_o && $past(tx_frame_sync_o) == 1'b0)
      else $error("first bit driven before the select led it");
   rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
      else $error("receive valid longer than one cycle");
   config_flag_a: assert property (clock_stop_mode_i != 2'h3 || (!master_i
      && (!srg_clock_source_select_i || srg_clock_divider_i != 8'h1)) |-> config_error_o)
      else $error("bad setting not flagged");
   refuse_start_a: assert property (config_error_o && !busy_o |=> !busy_o)
      else $error("transfer started with a bad setting");
endmodule
`default_nettype wire

/* File: verification/spi_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model #(
   parameter int W = 8
) (
   input wire logic         clk_i,
   input wire logic         sclk_i,
   input wire logic         sel_n_i,
   input wire logic         mosi_i,
   input wire logic         mosi_oe_n_i,
   input wire logic [W-1:0] reply_i,
   output logic             miso_o,
   output logic [W-1:0]     got_o
);
   logic       sclk_r = 1'b1;
   logic       junk_r = 1'b0;
   logic [3:0] idx_r = 4'h0;
   // Each bit is launched at a rise; outside a word the line floats, shown as a toggling level.
   assign miso_o = (sel_n_i || idx_r == 4'h0 || idx_r > W) ? junk_r : reply_i[W - idx_r];
   initial got_o = '0;
   always @(posedge clk_i) begin
      sclk_r <= sclk_i;
      junk_r <= ~junk_r;
      if (sel_n_i) idx_r <= 4'h0;
      else if (sclk_i && !sclk_r) idx_r <= idx_r + 4'h1;
      // Sampling at the fall keeps clear of the launch at the rise.
      if (!sel_n_i && !sclk_i && sclk_r && !mosi_oe_n_i) got_o <= {got_o[W-2:0], mosi_i};
   end
endmodule
`default_nettype wire

/* File: verification/test_spi_clock_stop.sv */
`timescale 1ns/1ps
`default_nettype none
module test_spi_clock_stop;
   logic clk_i = 1'b0, rst_i = 1'b1, master = 1'b1, src = 1'b1, pol = 1'b1, tx_valid = 1'b0;
   logic [1:0] mode = 2'h3;
   logic [7:0] div = 8'h1, tx_data = 8'h0, got;
   logic tx_ready, rx_valid, ck_o, ck_oe_n, fs_o, fs_oe_n, dout, dout_oe_n, busy, cfg_err;
   logic txc_dir, rxc_dir, txf_dir, rxf_dir, miso;
   logic [7:0] rx_data;
   logic ext_clk = 1'b0, m_ck = 1'b1, m_fs = 1'b1, srg_clk;
   logic [7:0] reply = 8'hC3;
   wire logic ck_pin = ck_oe_n ? m_ck : ck_o;
   wire logic fs_pin = fs_oe_n ? m_fs : fs_o;
   int errors = 0, n_checks = 0;
   always #50 clk_i = ~clk_i;
   spi_clock_stop uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .master_i(master),
      .clock_stop_mode_i(mode), .tx_clock_polarity_i(pol), .tx_fsync_polarity_i(pol),
      .rx_fsync_polarity_i(pol), .srg_clock_source_select_i(src), .srg_clock_divider_i(div),
      .srg_ext_clock_i(ext_clk), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
      .tx_data_i(tx_data), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .bit_clock_tx_i(ck_pin),
      .bit_clock_tx_o(ck_o), .bit_clock_tx_oe_n_o(ck_oe_n), .tx_frame_sync_i(fs_pin),
      .tx_frame_sync_o(fs_o), .tx_frame_sync_oe_n_o(fs_oe_n), .rx_frame_sync_i(1'b1),
      .serial_data_out_o(dout), .serial_data_out_oe_n_o(dout_oe_n), .serial_data_in_i(miso),
      .srg_output_clock_o(srg_clk), .busy_o(busy), .config_error_o(cfg_err),
      .tx_clock_dir_o(txc_dir), .rx_clock_dir_o(rxc_dir), .tx_fsync_dir_o(txf_dir),
      .rx_fsync_dir_o(rxf_dir));
   spi_slave_model #(.W(8)) partner (.clk_i(clk_i), .sclk_i(ck_pin), .sel_n_i(fs_pin),
      .mosi_i(dout), .mosi_oe_n_i(dout_oe_n), .reply_i(reply), .miso_o(miso), .got_o(got));
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] act, input logic [7:0] exp);
      n_checks++;
      if (act !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic timed_out();
      errors++;
      summarize();
   endtask
   // Leaves valid high so back-to-back pushes never drop it in between.
   task automatic push(input logic [7:0] w);
      int i;
      tx_data = w;
      tx_valid = 1'b1;
      for (i = 0; i < 200 && tx_ready !== 1'b1; i++) @(negedge clk_i);
      if (i == 200) timed_out();
      @(negedge clk_i);
   endtask
   task automatic expect_word(input logic [7:0] sent);
      int i;
      for (i = 0; i < 400 && rx_valid !== 1'b1; i++) @(negedge clk_i);
      if (i == 400) timed_out();
      check(rx_data, reply);
      check(got, sent);
      @(negedge clk_i);
   endtask
   task automatic master_back_to_back();
      for (int d = 1; d <= 3; d++) begin
         div = 8'(d);
         push(8'hA5);
         push(8'h3C);
         tx_valid = 1'b0;
         expect_word(8'hA5);
         expect_word(8'h3C);
         repeat (20) @(negedge clk_i);
         check({6'h0, fs_o, dout_oe_n}, 8'h3);
      end
   endtask
   task automatic fill_and_drain();
      mode = 2'h2;
      for (int k = 0; k < 8; k++) push(8'h10 + 8'(k));
      tx_valid = 1'b0;
      check({5'h0, tx_ready, busy, cfg_err}, 8'h1);
      mode = 2'h3;
      for (int k = 0; k < 8; k++) expect_word(8'h10 + 8'(k));
   endtask
   task automatic slave_word();
      master = 1'b0;
      div = 8'h1;
      reply = 8'h5A;
      push(8'h96);
      tx_valid = 1'b0;
      m_fs = 1'b0;
      repeat (6) @(negedge clk_i);
      for (int b = 0; b < 9; b++) begin
         m_ck = 1'b0;
         repeat (4) @(negedge clk_i);
         m_ck = 1'b1;
         repeat (4) @(negedge clk_i);
      end
      check({7'h0, busy}, 8'h1);
      m_fs = 1'b1;
      repeat (6) @(negedge clk_i);
      check(rx_data, 8'h5A);
      check(got, 8'h96);
      check({6'h0, busy, dout_oe_n}, 8'h1);
      master = 1'b1;
   endtask
   task automatic ext_clock_rate();
      logic lvl;
      int len, runs;
      src = 1'b0;
      div = 8'h1;
      lvl = srg_clk;
      len = 0;
      runs = 0;
      for (int c = 0; c < 120; c++) begin
         if (c % 3 == 0) ext_clk = ~ext_clk;
         @(negedge clk_i);
         len++;
         if (srg_clk !== lvl) begin
            if (runs >= 2) check(8'(len), 8'h6);
            runs++;
            len = 0;
            lvl = srg_clk;
         end
      end
      check(8'(runs > 10), 8'h1);
      src = 1'b1;
   endtask
   task automatic config_table();
      logic [11:0] t [5] = '{12'h601, 12'h702, 12'h301, 12'hD01, 12'hE01};
      for (int k = 0; k < 5; k++) begin
         {master, src, pol} = t[k][11:9];
         div = t[k][7:0];
         @(negedge clk_i);
         check({7'h0, cfg_err}, {7'h0, t[k][8]});
         check({4'h0, txc_dir, txf_dir, rxc_dir, rxf_dir}, {4'h0, master, master, 2'b0});
      end
   endtask
   initial begin
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      master_back_to_back();
      fill_and_drain();
      slave_word();
      ext_clock_rate();
      config_table();
      summarize();
   end
endmodule
bind spi_clock_stop spi_clock_stop_checker #(.WORD_BITS(WORD_BITS)) chk (.*);
`default_nettype wire
